// ### src/scqm_defs.vh
// constants for the stream class-of-service queue mapper
`ifndef SCQM_DEFS_VH
`define SCQM_DEFS_VH
`define SCQM_COS_W      8
`define SCQM_ID_W       8
`define SCQM_TAG_W      16
`define SCQM_FLOW_W     4
`define SCQM_ACT_DEPTH  8
`define SCQM_RST_FLOW   4'h0
`endif

// ### src/scqm_mapper.v
// stream class-of-service mapper: queue selection and per-stream gating
`timescale 1ns/1ps
`include "scqm_defs.vh"
module scqm_mapper #(
   parameter ID_W    = `SCQM_ID_W,
   parameter COS_W   = `SCQM_COS_W,
   parameter TAG_W   = `SCQM_TAG_W,
   parameter FLOW_W  = `SCQM_FLOW_W,
   parameter QSEL_W  = 2,
   parameter DEPTH   = `SCQM_ACT_DEPTH
) (
   // clock and reset
   input  wire                    clk_sys,
   input  wire                    srst,
   // outgoing segment request
   input  wire                    txValid,
   input  wire                    txFirst,
   input  wire                    txLast,
   input  wire [ID_W-1:0]         txDestId,
   input  wire [COS_W-1:0]        txCos,
   input  wire [TAG_W-1:0]        txTag,
   output reg                     txReady,
   // mapped outgoing segment
   output reg                     outValid,
   output reg                     outFirst,
   output reg                     outLast,
   output reg  [QSEL_W-1:0]       outQueue,
   output reg  [FLOW_W-1:0]       outFlow,
   output reg  [ID_W+COS_W+TAG_W-1:0] outKey,
   // queue to flow label table load
   input  wire                    mapWe,
   input  wire [QSEL_W-1:0]       mapIdx,
   input  wire [FLOW_W-1:0]       mapFlow,
   // incoming segment classification
   input  wire                    rxValid,
   input  wire [ID_W-1:0]         rxSrcId,
   input  wire [COS_W-1:0]        rxCos,
   input  wire [TAG_W-1:0]        rxTag,
   output reg                     inValid,
   output reg  [QSEL_W-1:0]       inQueue,
   output reg  [ID_W+COS_W+TAG_W-1:0] inKey,
   // status
   output reg                     busyFull
);
   localparam NQ   = 1 << QSEL_W;
   localparam KW   = ID_W + COS_W + TAG_W;
   localparam IDXW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // the queue index is the QSEL_W most significant service class bits
   function [QSEL_W-1:0] binOf;
      input [COS_W-1:0] cos;
      begin
         binOf = cos[COS_W-1 -: QSEL_W];
      end
   endfunction

   // one key layout for both directions: id, class, tag
   function [KW-1:0] keyOf;
      input [ID_W-1:0]  id;
      input [COS_W-1:0] cos;
      input [TAG_W-1:0] tag;
      begin
         keyOf = {id, cos, tag};
      end
   endfunction

   function keyMatch;
      input          vld;
      input [KW-1:0] a;
      input [KW-1:0] b;
      begin
         keyMatch = vld && (a == b);
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [FLOW_W-1:0] flowMap_r [0:NQ-1];
   reg [KW-1:0]     actKey_r  [0:DEPTH-1];
   reg [DEPTH-1:0]  actVld_r;
   reg              inUnit_r;
   reg [QSEL_W-1:0] curQ_r;
   reg [FLOW_W-1:0] curFlow_r;
   reg [KW-1:0]     curKey_r;

   wire [KW-1:0] txKey = keyOf(txDestId, txCos, txTag);
   reg           hit;
   reg           freeFound;
   reg [IDXW-1:0] freeIdx;
   integer i;
   integer j;
   integer r;
   integer m;
   reg [DEPTH-1:0] actVld_nxt;
   reg             inUnit_nxt;
   reg             slotWe;

   always @* begin
      hit = 1'b0;
      freeFound = 1'b0;
      freeIdx = {IDXW{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
         if (keyMatch(actVld_r[i], actKey_r[i], txKey))
            hit = 1'b1;
         if (!actVld_r[i] && !freeFound) begin
            freeFound = 1'b1;
            freeIdx = i[IDXW-1:0];
         end
      end
   end

   // a first segment of a stream already in flight stalls here
   wire startOk = !inUnit_r && txFirst && !hit && freeFound;
   wire contOk  = inUnit_r && !txFirst;
   wire accept  = txValid && (startOk || contOk);
   wire [QSEL_W-1:0] newQ = binOf(txCos);

   // ----------------------------------------
   // transmit path
   // ----------------------------------------
   // single-segment units never hold a slot
   always @* begin
      actVld_nxt = actVld_r;
      inUnit_nxt = inUnit_r;
      slotWe     = 1'b0;
      if (accept && startOk && !txLast) begin
         inUnit_nxt          = 1'b1;
         slotWe              = 1'b1;
         actVld_nxt[freeIdx] = 1'b1;
      end
      if (accept && contOk && txLast)
         inUnit_nxt = 1'b0;
      for (j = 0; j < DEPTH; j = j + 1)
         if (accept && contOk && txLast
             && keyMatch(actVld_r[j], actKey_r[j], curKey_r))
            actVld_nxt[j] = 1'b0;
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         for (r = 0; r < DEPTH; r = r + 1)
            actKey_r[r] <= {KW{1'b0}};
         actVld_r <= {DEPTH{1'b0}};
         inUnit_r <= 1'b0;
      end else begin
         actVld_r <= actVld_nxt;
         inUnit_r <= inUnit_nxt;
         if (slotWe)
            actKey_r[freeIdx] <= txKey;
      end
   end

   // ----------------------------------------
   // queue to flow label table
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         for (m = 0; m < NQ; m = m + 1)
            flowMap_r[m] <= `SCQM_RST_FLOW;
      end else if (mapWe) begin
         // a write lands for the next unit; an open unit keeps its label
         flowMap_r[mapIdx] <= mapFlow;
      end
   end

   // ----------------------------------------
   // mapped output
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         curQ_r    <= {QSEL_W{1'b0}};
         curFlow_r <= {FLOW_W{1'b0}};
         curKey_r  <= {KW{1'b0}};
         outValid  <= 1'b0;
         outFirst  <= 1'b0;
         outLast   <= 1'b0;
         outQueue  <= {QSEL_W{1'b0}};
         outFlow   <= {FLOW_W{1'b0}};
         outKey    <= {KW{1'b0}};
      end else begin
         outValid <= accept;
         outFirst <= accept && txFirst;
         outLast  <= accept && txLast;
         if (accept && startOk) begin
            // selection latched once so later segments cannot drift
            curQ_r    <= newQ;
            curFlow_r <= flowMap_r[newQ];
            curKey_r  <= txKey;
            outQueue  <= newQ;
            outFlow   <= flowMap_r[newQ];
            outKey    <= txKey;
         end else if (accept) begin
            outQueue <= curQ_r;
            outFlow  <= curFlow_r;
            outKey   <= curKey_r;
         end
      end
   end

   // ----------------------------------------
   // status
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         txReady  <= 1'b0;
         busyFull <= 1'b0;
      end else begin
         // a hint only: acceptance never waits on it
         txReady  <= inUnit_r ? 1'b1 : (freeFound && !hit);
         busyFull <= &actVld_r;
      end
   end

   // ----------------------------------------
   // receive classification
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         inValid <= 1'b0;
         inQueue <= {QSEL_W{1'b0}};
         inKey   <= {KW{1'b0}};
      end else begin
         inValid <= rxValid;
         // arrivals fan out by class for later re-injection
         inQueue <= binOf(rxCos);
         inKey   <= keyOf(rxSrcId, rxCos, rxTag);
      end
   end
endmodule

// ### tb/scqm_mapper_asserts.sv
// port checker for the stream queue mapper
`timescale 1ns/1ps
module scqm_mapper_asserts (
   input wire        clk_sys, srst, txValid, outValid, outFirst, outLast,
   input wire        rxValid, inValid,
   input wire [7:0]  txDestId, txCos, rxSrcId, rxCos,
   input wire [15:0] txTag, rxTag,
   input wire [1:0]  outQueue, inQueue,
   input wire [3:0]  outFlow,
   input wire [31:0] outKey, inKey
);
   reg open_r;
   // unit state rebuilt from the outputs alone
   always @(posedge clk_sys) begin
      if (srst)
         open_r <= 1'b0;
      else if (outValid)
         open_r <= !outLast;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_start; outValid && outFirst; endsequence
   sequence s_cont; outValid && !outFirst; endsequence
   property p_qsel; s_start |-> outQueue == outKey[23:22]; endproperty
   property p_okey; s_start |-> outKey == {$past(txDestId), $past(txCos),
      $past(txTag)}; endproperty
   property p_hold; s_cont |-> $stable(outKey) && $stable(outQueue)
      && $stable(outFlow); endproperty
   property p_one; s_start |-> !open_r; endproperty
   property p_cont; s_cont |-> open_r; endproperty
   property p_pulse; !$past(txValid) |-> !outValid; endproperty
   property p_ikey; rxValid |=> inValid && inKey == {$past(rxSrcId),
      $past(rxCos), $past(rxTag)}; endproperty
   property p_iq; inValid |-> inQueue == inKey[23:22]; endproperty
   a_qsel: assert property (p_qsel) else $error("queue bits");
   a_okey: assert property (p_okey) else $error("send key");
   a_hold: assert property (p_hold) else $error("unit moved");
   a_one: assert property (p_one) else $error("two units");
   a_cont: assert property (p_cont) else $error("no unit");
   a_pulse: assert property (p_pulse) else $error("spurious");
   a_ikey: assert property (p_ikey) else $error("recv key");
   a_iq: assert property (p_iq) else $error("in queue");
endmodule
bind scqm_mapper scqm_mapper_asserts chk (.clk_sys, .srst, .txValid,
   .outValid, .outFirst, .outLast, .rxValid, .inValid, .txDestId, .txCos,
   .rxSrcId, .rxCos, .txTag, .rxTag, .outQueue, .inQueue, .outFlow, .outKey,
   .inKey);

// ### tb/scqm_fabric.sv
// loopback fabric: one path, so segments return in issue order
`timescale 1ns/1ps
module scqm_fabric (
   input  wire        clk_sys, outValid,
   input  wire [31:0] outKey,
   output reg         rxValid = 1'b0,
   output reg  [7:0]  rxSrcId = 8'h00, rxCos = 8'h00,
   output reg  [15:0] rxTag = 16'h0000
);
   always @(posedge clk_sys) begin
      rxValid <= outValid;
      // idle lines invert so a stale value never looks valid
      {rxSrcId, rxCos, rxTag} <= outValid ? outKey
         : ~{rxSrcId, rxCos, rxTag};
   end
endmodule

// ### tb/scqm_mapper_tb.sv
// self-checking bench for the stream queue mapper
`timescale 1ns/1ps
module scqm_mapper_tb;
   reg clk_sys = 1'b0, srst = 1'b1, txValid = 1'b0, txFirst = 1'b0;
   reg txLast = 1'b0, mapWe = 1'b0;
   reg [7:0] txDestId = 8'h00, txCos = 8'h00;
   reg [15:0] txTag = 16'h0000;
   reg [1:0] mapIdx = 2'h0;
   reg [3:0] mapFlow = 4'h0;
   reg [3:0] flowTab [0:3] = '{4'h0, 4'h0, 4'h0, 4'h0};
   wire txReady, outValid, outFirst, outLast, rxValid, inValid, busyFull;
   wire [1:0] outQueue, inQueue;
   wire [3:0] outFlow;
   wire [7:0] rxSrcId, rxCos;
   wire [15:0] rxTag;
   wire [31:0] outKey, inKey;
   reg [39:0] expOut [$];
   reg [33:0] expIn [$];
   reg [39:0] eo;
   reg [33:0] ei;
   int nErrors = 0, checked = 0;
   always #5 clk_sys = ~clk_sys;
   scqm_mapper uut (.clk_sys, .srst, .txValid, .txFirst, .txLast, .txDestId,
      .txCos, .txTag, .txReady, .outValid, .outFirst, .outLast, .outQueue,
      .outFlow, .outKey, .mapWe, .mapIdx, .mapFlow, .rxValid, .rxSrcId,
      .rxCos, .rxTag, .inValid, .inQueue, .inKey, .busyFull);
   scqm_fabric fab (.clk_sys, .outValid, .outKey, .rxValid, .rxSrcId,
      .rxCos, .rxTag);
   task automatic tally(input logic [39:0] g, e);
      checked++;
      if (g !== e) begin
         nErrors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmpOut(input logic [39:0] g, e);
      tally(g, e);
   endtask
   task automatic cmpIn(input logic [33:0] g, e);
      tally({6'h00, g}, {6'h00, e});
   endtask
   task automatic cmpStat(input logic [3:0] g, e);
      tally({36'h0, g}, {36'h0, e});
   endtask
   task automatic results;
      $display("errors=%0d checks=%0d", nErrors, checked);
      if (nErrors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      #2;
      if (outValid === 1'b1) begin
         eo = expOut.size() ? expOut.pop_front() : 'x;
         cmpOut({outFirst, outLast, outFlow, outQueue, outKey}, eo);
      end
      if (inValid === 1'b1) begin
         ei = expIn.size() ? expIn.pop_front() : 'x;
         cmpIn({inQueue, inKey}, ei);
      end
   end
   // segment held until taken; bounded so a stall ends the run
   task automatic seg(input logic f, l, input logic [31:0] k,
      input logic [37:0] e);
      int i;
      {txFirst, txLast, txDestId, txCos, txTag} = {f, l, k};
      txValid = 1'b1;
      expOut.push_back({f, l, e});
      expIn.push_back(e[33:0]);
      i = 0;
      do begin
         @(posedge clk_sys) #1 i++;
      end while (outValid !== 1'b1 && i < 20);
      if (outValid !== 1'b1) begin
         nErrors++;
         results;
      end
   endtask
   initial begin
      int u, n, s;
      logic [31:0] k;
      void'($urandom(32'h75F2));
      repeat (10) @(posedge clk_sys);
      #1 cmpStat({outValid, inValid, txReady, busyFull}, 4'h0);
      srst = 1'b0;
      // a continuation with no unit open must not be taken
      {txValid, txFirst} = 2'b10;
      repeat (3) @(posedge clk_sys);
      #1 cmpStat({outValid, inValid, txReady, busyFull}, 4'h2);
      for (u = 0; u < 16; u++) begin
         if (u == 8) begin
            txValid = 1'b0;
            for (s = 0; s < 4; s++) begin
               {mapWe, mapIdx, mapFlow} = {1'b1, 2'(s), 4'($urandom)};
               flowTab[s] = mapFlow;
               @(posedge clk_sys) #1;
            end
            mapWe = 1'b0;
         end
         k = $urandom;
         n = $urandom_range(1, 3);
         for (s = 0; s < n; s++)
            seg(s == 0, s == n - 1, s == 0 ? k : $urandom,
               {flowTab[k[23:22]], k[23:22], k});
      end
      // a new first with the same key while a unit is open must wait
      k = $urandom;
      seg(1'b1, 1'b0, k, {flowTab[k[23:22]], k[23:22], k});
      {txFirst, txLast} = 2'b11;
      repeat (3) @(posedge clk_sys);
      #1 cmpStat({outValid, inValid, txReady, busyFull}, 4'h2);
      seg(1'b0, 1'b1, k, {flowTab[k[23:22]], k[23:22], k});
      txValid = 1'b0;
      repeat (4) @(posedge clk_sys);
      cmpStat(4'(expOut.size() + expIn.size()), 4'h0);
      results;
   end
endmodule
